// ==== logic/mrs_pkg.sv ====
// How it works
// - power-up settles ready, awaits switch-on
// - switch-on in ready goes to wait enable, stays off
// - normal stop ramps, off at standstill
// - coast stop de-energises immediately
// - quick stop uses quick ramp time
// - disable operation: off, setpoint blocked
// - enable operation: on, setpoint passed
// - inhibited ignores on; coast/quick enter it
// - on active at power-up inhibits start unless auto-restart is set
// - path: ready, wait enable, motor on
// - normal ramp versus separate quick ramp
// - run low stops; reverse picks direction
// - reverse ignored until negative released
// - preset twelve maps inputs zero, one
// - run source selectable per data set
// - reverse source selectable per data set
package mrs_pkg;
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_SRC0 = 12'h004;
	localparam logic [11:0] ADDR_SRC1 = 12'h008;
	localparam logic [11:0] ADDR_STAT = 12'h00C;
	localparam int CTRL_PRESET_LSB = 0;
	localparam int CTRL_CDS_BIT = 8;
	localparam int CTRL_REVEN_BIT = 9;
	localparam int CTRL_AUTORS_BIT = 10;
	localparam int CTRL_ENOP_BIT = 11;
	localparam int CTRL_COAST_BIT = 12;
	localparam int CTRL_QUICK_BIT = 13;
	localparam logic [7:0] PRESET_TWO_WIRE_1 = 8'h0C;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] SRC_RESET = 32'h0000_0100;
	localparam int POWERUP_SETTLE = 2;
	typedef enum {
		ST_INHIBIT, ST_READY, ST_WAIT_EN, ST_RUN, ST_RAMP_NORM, ST_RAMP_QUICK
	} mrs_state_e;
	typedef struct packed {
		logic energised;
		logic setpointPass;
		logic reverse;
		logic rampNormal;
		logic rampQuick;
	} mrs_drive_s;
endpackage

// ==== logic/mrs_sequencer.sv ====
`timescale 1ns/1ps
module mrs_sequencer #(
	parameter int NumInputs = 8
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NumInputs-1:0] digitalInputs,
	input wire logic standstill,
	output mrs_pkg::mrs_drive_s drive
);
	logic rstMeta, rstSync;
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rstMeta <= 1'b0;
			rstSync <= 1'b0;
		end
		else
		begin
			rstMeta <= 1'b1;
			rstSync <= rstMeta;
		end
	end

	// two-stage synchroniser on every input pin
	logic [NumInputs-1:0] diMeta, diSync;
	logic stillMeta, stillSync;
	always_ff @(posedge mclk or negedge rstSync)
	begin
		if (!rstSync)
		begin
			diMeta <= '0;
			diSync <= '0;
			stillMeta <= 1'b0;
			stillSync <= 1'b0;
		end
		else
		begin
			diMeta <= digitalInputs;
			diSync <= diMeta;
			stillMeta <= standstill;
			stillSync <= stillMeta;
		end
	end

	// registers
	logic [31:0] ctrl_q, ctrl_d, src0_q, src0_d, src1_q, src1_d, prdata_q, prdata_d;
	logic pready_q, pready_d, pslverr_q, pslverr_d;
	mrs_pkg::mrs_state_e state_q, state_d;
	logic access, commit;
	assign access = psel && penable && !pready_q;
	// writes land on the edge at which the master sees pready, not one edge early
	assign commit = psel && penable && pready_q && pwrite;

	always_comb
	begin
		ctrl_d = ctrl_q;
		src0_d = src0_q;
		src1_d = src1_q;
		prdata_d = prdata_q;
		pslverr_d = 1'b0;
		pready_d = access;
		if (access)
		begin
			case (paddr)
				mrs_pkg::ADDR_CTRL:
				begin
					prdata_d = ctrl_q;
				end
				mrs_pkg::ADDR_SRC0:
				begin
					prdata_d = src0_q;
				end
				mrs_pkg::ADDR_SRC1:
				begin
					prdata_d = src1_q;
				end
				mrs_pkg::ADDR_STAT:
				begin
					prdata_d = {24'h000000, drive, 3'(state_q)};
					pslverr_d = pwrite;
				end
				default:
				begin
					prdata_d = 32'h0000_0000;
					pslverr_d = 1'b1;
				end
			endcase
		end
		if (commit)
		begin
			case (paddr)
				mrs_pkg::ADDR_CTRL:
					ctrl_d = pwdata;
				mrs_pkg::ADDR_SRC0:
					src0_d = pwdata;
				mrs_pkg::ADDR_SRC1:
					src1_d = pwdata;
				default:
					ctrl_d = ctrl_q;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rstSync)
	begin
		if (!rstSync)
		begin
			ctrl_q <= mrs_pkg::CTRL_RESET;
			src0_q <= mrs_pkg::SRC_RESET;
			src1_q <= mrs_pkg::SRC_RESET;
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			src0_q <= src0_d;
			src1_q <= src1_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;

	// source select: byte k of a source register is data set k, whole byte is input number, at or above NumInputs reads low
	logic command_data_set, presetFixed, revEnable, autoRestart, enableOp, coastCmd, quickCmd;
	logic [7:0] runSel, revSel;
	logic runCmd, revCmd;
	assign command_data_set = ctrl_q[mrs_pkg::CTRL_CDS_BIT];
	assign presetFixed = ctrl_q[mrs_pkg::CTRL_PRESET_LSB +: 8] == mrs_pkg::PRESET_TWO_WIRE_1;
	assign revEnable = ctrl_q[mrs_pkg::CTRL_REVEN_BIT];
	assign autoRestart = ctrl_q[mrs_pkg::CTRL_AUTORS_BIT];
	assign enableOp = ctrl_q[mrs_pkg::CTRL_ENOP_BIT];
	assign coastCmd = ctrl_q[mrs_pkg::CTRL_COAST_BIT];
	assign quickCmd = ctrl_q[mrs_pkg::CTRL_QUICK_BIT];
	assign runSel = presetFixed ? 8'h00 : (command_data_set ? src0_q[15:8] : src0_q[7:0]);
	assign revSel = presetFixed ? 8'h01 : (command_data_set ? src1_q[15:8] : src1_q[7:0]);
	assign runCmd = (runSel < 8'(NumInputs)) ? diSync[runSel[$clog2(NumInputs)-1:0]] : 1'b0;
	assign revCmd = (revSel < 8'(NumInputs)) ? diSync[revSel[$clog2(NumInputs)-1:0]] : 1'b0;

	// power-up check: run already high on first look means inhibit, unless auto-restart is set
	logic first_q, first_d;
	logic [1:0] settle_q, settle_d;
	mrs_pkg::mrs_drive_s drive_q, drive_d;
	always_comb
	begin
		state_d = state_q;
		first_d = first_q && (settle_q != 2'(mrs_pkg::POWERUP_SETTLE));
		settle_d = first_q ? settle_q + 2'h1 : settle_q;
		if (first_q)
		begin
			// pins need two edges through the synchroniser; judging earlier always sees low
			if (settle_q == 2'(mrs_pkg::POWERUP_SETTLE))
				state_d = (runCmd && !autoRestart) ? mrs_pkg::ST_INHIBIT : mrs_pkg::ST_READY;
		end
		else if (coastCmd)
			state_d = mrs_pkg::ST_INHIBIT;
		else
		begin
			case (state_q)
				mrs_pkg::ST_INHIBIT:
					if (!runCmd && !quickCmd)
						state_d = mrs_pkg::ST_READY;
				mrs_pkg::ST_READY:
					if (quickCmd)
						state_d = mrs_pkg::ST_INHIBIT;
					else if (runCmd)
						state_d = mrs_pkg::ST_WAIT_EN;
				mrs_pkg::ST_WAIT_EN:
					if (quickCmd)
						state_d = mrs_pkg::ST_INHIBIT;
					else if (!runCmd)
						state_d = mrs_pkg::ST_READY;
					else if (enableOp)
						state_d = mrs_pkg::ST_RUN;
				mrs_pkg::ST_RUN:
					if (quickCmd)
						state_d = mrs_pkg::ST_RAMP_QUICK;
					else if (!runCmd)
						state_d = mrs_pkg::ST_RAMP_NORM;
					else if (!enableOp)
						state_d = mrs_pkg::ST_WAIT_EN;
				mrs_pkg::ST_RAMP_NORM:
					if (quickCmd)
						state_d = mrs_pkg::ST_RAMP_QUICK;
					else if (stillSync)
						state_d = mrs_pkg::ST_READY;
				mrs_pkg::ST_RAMP_QUICK:
					if (stillSync)
						state_d = mrs_pkg::ST_INHIBIT;
				default:
					state_d = mrs_pkg::ST_INHIBIT;
			endcase
		end
		drive_d.energised = state_d inside {mrs_pkg::ST_RUN, mrs_pkg::ST_RAMP_NORM, mrs_pkg::ST_RAMP_QUICK};
		drive_d.setpointPass = state_d == mrs_pkg::ST_RUN;
		drive_d.reverse = revEnable && revCmd;
		drive_d.rampNormal = state_d == mrs_pkg::ST_RAMP_NORM;
		drive_d.rampQuick = state_d == mrs_pkg::ST_RAMP_QUICK;
	end

	always_ff @(posedge mclk or negedge rstSync)
	begin
		if (!rstSync)
		begin
			state_q <= mrs_pkg::ST_INHIBIT;
			first_q <= 1'b1;
			settle_q <= 2'h0;
			drive_q <= '0;
		end
		else
		begin
			state_q <= state_d;
			first_q <= first_d;
			settle_q <= settle_d;
			drive_q <= drive_d;
		end
	end
	assign drive = drive_q;

	energised_matches_a: assert property (@(posedge mclk) disable iff (!rstSync)
		1'b1 |=> drive.energised == (state_q inside {mrs_pkg::ST_RUN, mrs_pkg::ST_RAMP_NORM, mrs_pkg::ST_RAMP_QUICK}))
		else $error("energise output disagrees with state");
	coast_inhibit_a: assert property (@(posedge mclk) disable iff (!rstSync)
		coastCmd && !first_q |=> state_q == mrs_pkg::ST_INHIBIT && !drive.energised)
		else $error("coast stop did not de-energise");
	normal_stop_a: assert property (@(posedge mclk) disable iff (!rstSync)
		state_q == mrs_pkg::ST_RUN && !runCmd && !quickCmd && !coastCmd |=> state_q == mrs_pkg::ST_RAMP_NORM)
		else $error("normal stop did not ramp");
	ramp_ends_a: assert property (@(posedge mclk) disable iff (!rstSync)
		state_q == mrs_pkg::ST_RAMP_NORM && stillSync && !quickCmd && !coastCmd |=> state_q == mrs_pkg::ST_READY)
		else $error("normal ramp did not end at standstill");
	quick_stop_a: assert property (@(posedge mclk) disable iff (!rstSync)
		state_q == mrs_pkg::ST_RUN && quickCmd && !coastCmd |=> state_q == mrs_pkg::ST_RAMP_QUICK ##1 drive.rampQuick)
		else $error("quick stop did not use quick ramp");
	inhibit_ignores_a: assert property (@(posedge mclk) disable iff (!rstSync)
		state_q == mrs_pkg::ST_INHIBIT && !first_q |=> state_q != mrs_pkg::ST_WAIT_EN && state_q != mrs_pkg::ST_RUN)
		else $error("inhibit state accepted switch-on");
	run_needs_wait_a: assert property (@(posedge mclk) disable iff (!rstSync)
		state_q == mrs_pkg::ST_RUN && $past(state_q) != mrs_pkg::ST_RUN |-> $past(state_q) == mrs_pkg::ST_WAIT_EN)
		else $error("motor on reached without waiting for enable");
	reverse_gate_a: assert property (@(posedge mclk) disable iff (!rstSync)
		!revEnable |=> !drive.reverse)
		else $error("reverse active while not released");
	switch_on_a: assert property (@(posedge mclk) disable iff (!rstSync)
		state_q == mrs_pkg::ST_READY && runCmd && !quickCmd && !coastCmd |=> state_q == mrs_pkg::ST_WAIT_EN)
		else $error("switch-on in ready did not wait for enable");
	enable_run_a: assert property (@(posedge mclk) disable iff (!rstSync)
		state_q == mrs_pkg::ST_WAIT_EN && runCmd && enableOp && !quickCmd && !coastCmd
		|=> drive.energised && drive.setpointPass)
		else $error("enable did not pass setpoint");
	disable_block_a: assert property (@(posedge mclk) disable iff (!rstSync)
		state_q == mrs_pkg::ST_RUN && runCmd && !enableOp && !quickCmd && !coastCmd
		|=> !drive.setpointPass && !drive.energised)
		else $error("disable left setpoint passing");
	quick_end_a: assert property (@(posedge mclk) disable iff (!rstSync)
		state_q == mrs_pkg::ST_RAMP_QUICK && stillSync && !coastCmd |=> state_q == mrs_pkg::ST_INHIBIT)
		else $error("quick ramp did not end in inhibit");
	powerup_inhibit_a: assert property (@(posedge mclk) disable iff (!rstSync)
		first_q && settle_q == 2'(mrs_pkg::POWERUP_SETTLE) && runCmd && !autoRestart
		|=> state_q == mrs_pkg::ST_INHIBIT)
		else $error("run active at power-up did not inhibit");
	powerup_ready_a: assert property (@(posedge mclk) disable iff (!rstSync)
		first_q && settle_q == 2'(mrs_pkg::POWERUP_SETTLE) && !runCmd |=> state_q == mrs_pkg::ST_READY)
		else $error("power-up did not settle in ready");
	ramp_flags_a: assert property (@(posedge mclk) disable iff (!rstSync)
		drive.rampNormal || drive.rampQuick |-> drive.energised && !drive.setpointPass)
		else $error("ramp state with wrong drive flags");
	reverse_follow_a: assert property (@(posedge mclk) disable iff (!rstSync)
		revEnable && revCmd |=> drive.reverse)
		else $error("released reverse input not followed");
	pready_pulse_a: assert property (@(posedge mclk) disable iff (!rstSync)
		pready |=> !pready)
		else $error("pready held longer than one cycle");
	write_lands_a: assert property (@(posedge mclk) disable iff (!rstSync)
		psel && penable && pready && pwrite && paddr == mrs_pkg::ADDR_CTRL |=> ctrl_q == $past(pwdata))
		else $error("control write did not land");
	stat_write_err_a: assert property (@(posedge mclk) disable iff (!rstSync)
		psel && penable && !pready && pwrite && paddr == mrs_pkg::ADDR_STAT |=> pready && pslverr)
		else $error("status write not refused");
	cover_run_c: cover property (@(posedge mclk) disable iff (!rstSync) state_q == mrs_pkg::ST_RUN);
	cover_inhibit_c: cover property (@(posedge mclk) disable iff (!rstSync)
		first_q && settle_q == 2'(mrs_pkg::POWERUP_SETTLE) && runCmd);
	cover_norm_c: cover property (@(posedge mclk) disable iff (!rstSync)
		state_q == mrs_pkg::ST_RAMP_NORM ##1 state_q == mrs_pkg::ST_READY);
	cover_quick_c: cover property (@(posedge mclk) disable iff (!rstSync) state_q == mrs_pkg::ST_RAMP_QUICK);
	cover_rev_c: cover property (@(posedge mclk) disable iff (!rstSync) drive.reverse && drive.setpointPass);
endmodule // mrs_sequencer

// ==== tb/mrs_ctrl_model.sv ====
`timescale 1ns/1ps
module mrs_ctrl_model (
	input wire logic mclk,
	input wire logic [7:0] pinVal,
	input wire logic [7:0] pinMask,
	input wire logic [31:0] stopDelay,
	input wire mrs_pkg::mrs_drive_s drive,
	output logic [7:0] digitalInputs = 8'h01,
	output logic standstill = 1'b1
);
	int cnt = 0;
	always @(posedge mclk)
	begin
		// pins nobody listens to toggle, so a wrong mapping shows up
		digitalInputs <= (pinVal & pinMask) | (8'($urandom) & ~pinMask);
		cnt <= (drive.rampNormal | drive.rampQuick) ? cnt + 1 : 0;
		standstill <= (drive.rampNormal | drive.rampQuick) ? cnt >= stopDelay : !drive.energised;
	end
endmodule // mrs_ctrl_model

// ==== tb/motor_run_stop_sequencer_test.sv ====
`timescale 1ns/1ps
`define CHK(a, b) \
	begin \
		checks_done++; \
		if ((a) !== (b)) \
		begin \
			errors++; \
			$display("Error at %0t: got %h expected %h", $time, a, b); \
		end \
	end
module motor_run_stop_sequencer_test;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, standstill, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [7:0] digitalInputs, pinVal = 8'h01, pinMask = 8'h01, preset = mrs_pkg::PRESET_TWO_WIRE_1;
	logic run = 1'b1, rev = 1'b0, enop = 1'b0, coast = 1'b0, quick = 1'b0, reven = 1'b0, command_data_set = 1'b0, ss;
	mrs_pkg::mrs_drive_s drive;
	int errors = 0, checks_done = 0, stopDelay = 30, st = 0, runIdx = 0, revIdx = 1;
	logic [6:0] seq [22] = '{7'h01, 7'h00, 7'h01, 7'h05, 7'h27, 7'h25, 7'h21, 7'h25, 7'h24, 7'h64, 7'h25,
		7'h35, 7'h75, 7'h25, 7'h24, 7'h25, 7'h2D, 7'h24, 7'h24, 7'h25, 7'h27, 7'h66};
	initial forever #25 mclk = ~mclk;
	mrs_sequencer u_dut (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.digitalInputs(digitalInputs), .standstill(standstill), .drive(drive));
	mrs_ctrl_model u_ctrl (.mclk(mclk), .pinVal(pinVal), .pinMask(pinMask), .stopDelay(stopDelay),
		.drive(drive), .digitalInputs(digitalInputs), .standstill(standstill));
	task automatic summarize();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
			errors++;
		@(posedge mclk);
	endtask
	function automatic int nxt(int s);
		if (coast)
			return 0;
		case (s)
			0: return (!run && !quick) ? 1 : 0;
			1: return quick ? 0 : (run ? 2 : 1);
			2: return quick ? 0 : (!run ? 1 : (enop ? 3 : 2));
			3: return quick ? 5 : (!run ? 4 : (enop ? 3 : 2));
			4: return ss ? 1 : 4;
			default: return ss ? 0 : 5;
		endcase
	endfunction
	task automatic step();
		logic [4:0] dv;
		apb(1'b1, mrs_pkg::ADDR_CTRL, {18'h0, quick, coast, enop, 1'b0, reven, command_data_set, preset});
		pinVal <= 8'(run) << runIdx | 8'(rev) << revIdx;
		// reverse pin left random while not released
		pinMask <= 8'h1 << runIdx | 8'(reven) << revIdx;
		repeat (ss ? 60 : 8) @(posedge mclk);
		repeat (6) st = nxt(st);
		apb(1'b0, mrs_pkg::ADDR_STAT, 32'h0);
		dv = {st >= 3, st == 3, reven && rev, st == 4, st == 5};
		`CHK(rd[2:0], 3'(st))
		`CHK(drive, dv)
		`CHK(rd[7:3], dv)
	endtask
	initial
	begin
		#1000000;
		errors++;
		summarize();
	end
	initial
	begin
		void'($urandom(32'h3fe75a64));
		stopDelay = 20 + $urandom % 20;
		repeat (16) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (4) @(posedge mclk);
		apb(1'b0, mrs_pkg::ADDR_SRC0, 32'h0);
		`CHK(rd, mrs_pkg::SRC_RESET)
		apb(1'b0, mrs_pkg::ADDR_CTRL, 32'h0);
		`CHK(rd, mrs_pkg::CTRL_RESET)
		apb(1'b0, 12'h010, 32'h0);
		`CHK({rd, err}, 33'h1)
		apb(1'b1, mrs_pkg::ADDR_STAT, 32'hFF);
		`CHK(err, 1'b1)
		foreach (seq[i])
		begin
			if (i == 18)
			begin
				// sources only matter once the preset is left; park both run pins low first
				apb(1'b1, mrs_pkg::ADDR_SRC0, 32'h0303);
				apb(1'b1, mrs_pkg::ADDR_SRC1, 32'h0505);
				pinVal <= 8'h00;
				pinMask <= 8'h09;
				repeat (8) @(posedge mclk);
				preset = 8'h00;
				command_data_set = 1'b1;
				runIdx = 3;
				revIdx = 5;
			end
			{ss, reven, quick, coast, enop, rev, run} = seq[i];
			step();
		end
		summarize();
	end
endmodule // motor_run_stop_sequencer_test
